// *** shared/cpd_pkg.sv ***
// Constants and types shared by the configuration port access decoder
package cpd_pkg;
   // Access state, Gray coded along run -> configuration -> run
   typedef enum logic [0:0] {
      CPD_ST_RUN = 1'b0,
      CPD_ST_CFG = 1'b1
   } cpd_state_t;

   // Key bytes written to the configuration port
   localparam logic [7:0]  CPD_KEY_ENTER   = 8'h55;
   localparam logic [7:0]  CPD_KEY_EXIT    = 8'hAA;

   // Indices reached through the index and data ports
   localparam logic [7:0]  CPD_IDX_LDN     = 8'h07;
   localparam logic [7:0]  CPD_IDX_BASE_LO = 8'h26;
   localparam logic [7:0]  CPD_IDX_BASE_HI = 8'h27;

   // Strap-selected base address bytes
   localparam logic [7:0]  CPD_LOW_STRAP0  = 8'h2E;
   localparam logic [7:0]  CPD_LOW_STRAP1  = 8'h4E;
   localparam logic [7:0]  CPD_HIGH_STRAP0 = 8'h16;
   localparam logic [7:0]  CPD_HIGH_STRAP1 = 8'h00;

   // Reset values held until the straps are caught
   localparam logic [7:0]  CPD_RST_BASE_LO = 8'h2E;
   localparam logic [7:0]  CPD_RST_BASE_HI = 8'h00;
   localparam logic [7:0]  CPD_RST_BYTE    = 8'h00;
   localparam logic [1:0]  CPD_RST_STRAP   = 2'h0;

   // Data port sits one address above the index port
   localparam logic [15:0] CPD_DATA_OFFSET = 16'h0001;
endpackage : cpd_pkg

// *** verilog/cpd_config_port_decoder.sv ***
// Configuration port access decoder: strap latch, key state machine, index/data ports
// Notes on behaviour
// R01: Reset leaves run state, all devices disabled
// R02: Index and data ports work only in configuration
// R03: Low strap picks low byte 0x2E or 0x4E
// R04: High strap picks high byte 0x16 or 0x00
// R05: Defaults are 002E, 004E, 162E or 164E
// R06: Indices 0x26/0x27 relocate the port address
// R07: Key 0x55 enters configuration state
// R08: Key 0xAA returns to run state
// R09: Index at base, data at base plus one
// R10: Host selects device via index 0x07 first
// R11: Only run and configuration; run accepts entry
// R12: Other run-state writes to port are ignored
`timescale 1ns/10ps
`default_nettype none
module cpd_config_port_decoder (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  cfg_addr_low_strap_in,
   input  wire logic                  cfg_addr_high_strap_in,
   input  wire logic                  io_wr_in,
   input  wire logic                  io_rd_in,
   input  wire logic [15:0]           io_addr_in,
   input  wire logic [7:0]            io_wdata_in,
   input  wire logic [7:0]            cfg_rdata_in,
   output logic      [7:0]            io_rdata_out,
   output logic                       io_claim_out,
   output cpd_pkg::cpd_state_t        cfg_state_out,
   output logic                       cfg_wr_out,
   output logic      [7:0]            cfg_index_out,
   output logic      [7:0]            cfg_wdata_out,
   output logic      [7:0]            ldn_out,
   output logic      [15:0]           cfg_base_addr_out,
   output logic      [1:0]            base_addr_strap_value_out
);
   import cpd_pkg::*;

   cpd_state_t  state_q,   state_d;
   logic        strap_done_q, strap_done_d;
   logic [1:0]  strap_q,   strap_d;
   logic [7:0]  base_lo_q, base_lo_d;
   logic [7:0]  base_hi_q, base_hi_d;
   logic [7:0]  index_q,   index_d;
   logic [7:0]  ldn_q,     ldn_d;
   logic [7:0]  rdata_q,   rdata_d;
   logic [7:0]  wdata_q,   wdata_d;
   logic        claim_q,   claim_d;
   logic        cfg_wr_q,  cfg_wr_d;
   logic [15:0] base_addr;
   logic        hit_cfg;
   logic        hit_data;

   // Address compare against a port, shared by both port decodes
   function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
      port_hit = (addr == port);
   endfunction : port_hit

   // Port decode; a relocation takes effect the cycle after the data write
   assign base_addr = {base_hi_q, base_lo_q};
   assign hit_cfg   = port_hit(io_addr_in, base_addr);                        // R09
   assign hit_data  = port_hit(io_addr_in, 16'(base_addr + CPD_DATA_OFFSET)); // R09

   // Next state: strap capture on the first edge after reset, then host cycles
   always_comb begin
      state_d      = state_q;
      strap_done_d = 1'b1;
      strap_d      = strap_q;
      base_lo_d    = base_lo_q;
      base_hi_d    = base_hi_q;
      index_d      = index_q;
      ldn_d        = ldn_q;
      rdata_d      = rdata_q;
      wdata_d      = wdata_q;
      claim_d      = 1'b0;
      cfg_wr_d     = 1'b0;
      if (!strap_done_q) begin
         // Straps are level inputs; catching them clocked keeps reset purely constant
         strap_d   = {cfg_addr_high_strap_in, cfg_addr_low_strap_in};
         base_lo_d = cfg_addr_low_strap_in  ? CPD_LOW_STRAP1  : CPD_LOW_STRAP0;  // R03 R05
         base_hi_d = cfg_addr_high_strap_in ? CPD_HIGH_STRAP1 : CPD_HIGH_STRAP0; // R04 R05
      end else begin
         case (state_q)
            CPD_ST_RUN: begin
               // Only the entry key counts; every other run access is left alone
               if (io_wr_in && hit_cfg && io_wdata_in == CPD_KEY_ENTER) begin // R07 R11 R12
                  state_d = CPD_ST_CFG;
                  claim_d = 1'b1;
               end
            end
            CPD_ST_CFG: begin // R02
               if (io_wr_in && hit_cfg) begin
                  claim_d = 1'b1;
                  if (io_wdata_in == CPD_KEY_EXIT) begin
                     state_d = CPD_ST_RUN; // R08
                  end else begin
                     index_d = io_wdata_in; // R09
                  end
               end else if (io_wr_in && hit_data) begin
                  claim_d = 1'b1;
                  case (index_q)
                     CPD_IDX_LDN:     ldn_d     = io_wdata_in;
                     CPD_IDX_BASE_LO: base_lo_d = io_wdata_in; // R06
                     CPD_IDX_BASE_HI: base_hi_d = io_wdata_in; // R06
                     default: begin
                        cfg_wr_d = 1'b1;
                        wdata_d  = io_wdata_in;
                     end
                  endcase
               end else if (io_rd_in && hit_cfg) begin
                  claim_d = 1'b1;
                  rdata_d = index_q;
               end else if (io_rd_in && hit_data) begin
                  claim_d = 1'b1;
                  case (index_q)
                     CPD_IDX_LDN:     rdata_d = ldn_q;
                     CPD_IDX_BASE_LO: rdata_d = base_lo_q;
                     CPD_IDX_BASE_HI: rdata_d = base_hi_q;
                     default:         rdata_d = cfg_rdata_in;
                  endcase
               end
            end
            default: state_d = CPD_ST_RUN;
         endcase
      end
   end

   // State registers; device number zero keeps every logical device disabled
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q      <= CPD_ST_RUN; // R01
         strap_done_q <= 1'b0;
         strap_q      <= CPD_RST_STRAP;
         base_lo_q    <= CPD_RST_BASE_LO;
         base_hi_q    <= CPD_RST_BASE_HI;
         index_q      <= CPD_RST_BYTE;
         ldn_q        <= CPD_RST_BYTE; // R01
         rdata_q      <= CPD_RST_BYTE;
         wdata_q      <= CPD_RST_BYTE;
         claim_q      <= 1'b0;
         cfg_wr_q     <= 1'b0;
      end else begin
         state_q      <= state_d;
         strap_done_q <= strap_done_d;
         strap_q      <= strap_d;
         base_lo_q    <= base_lo_d;
         base_hi_q    <= base_hi_d;
         index_q      <= index_d;
         ldn_q        <= ldn_d;
         rdata_q      <= rdata_d;
         wdata_q      <= wdata_d;
         claim_q      <= claim_d;
         cfg_wr_q     <= cfg_wr_d;
      end
   end

   // Outputs straight from flip-flops
   assign io_rdata_out              = rdata_q;
   assign io_claim_out              = claim_q;
   assign cfg_state_out             = state_q;
   assign cfg_wr_out                = cfg_wr_q;
   assign cfg_index_out             = index_q;
   assign cfg_wdata_out             = wdata_q;
   assign ldn_out                   = ldn_q;
   assign cfg_base_addr_out         = base_addr;
   assign base_addr_strap_value_out = strap_q;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_enter_key;
      strap_done_q && state_q == CPD_ST_RUN && io_wr_in && hit_cfg
         && io_wdata_in == CPD_KEY_ENTER;
   endsequence
   sequence s_cfg_data_wr;
      strap_done_q && state_q == CPD_ST_CFG && io_wr_in && !hit_cfg && hit_data;
   endsequence

   property p_run_until_strap;
      !strap_done_q |-> state_q == CPD_ST_RUN && ldn_q == CPD_RST_BYTE;
   endproperty
   a_run_until_strap: assert property (p_run_until_strap) else $error("not run at reset"); // R01

   property p_data_dead_in_run;
      strap_done_q && state_q == CPD_ST_RUN && io_wr_in && !hit_cfg && hit_data
         |=> !cfg_wr_out && !io_claim_out && $stable(ldn_q) && $stable(base_addr);
   endproperty
   a_data_dead_in_run: assert property (p_data_dead_in_run) else $error("data port live in run"); // R02

   property p_low_strap;
      $rose(strap_done_q) |-> base_lo_q ==
         ($past(cfg_addr_low_strap_in) ? CPD_LOW_STRAP1 : CPD_LOW_STRAP0);
   endproperty
   a_low_strap: assert property (p_low_strap) else $error("low strap byte wrong"); // R03

   property p_high_strap;
      $rose(strap_done_q) |-> base_hi_q ==
         ($past(cfg_addr_high_strap_in) ? CPD_HIGH_STRAP1 : CPD_HIGH_STRAP0);
   endproperty
   a_high_strap: assert property (p_high_strap) else $error("high strap byte wrong"); // R04

   property p_four_defaults;
      $rose(strap_done_q) |-> base_addr inside {16'h002E, 16'h004E, 16'h162E, 16'h164E};
   endproperty
   a_four_defaults: assert property (p_four_defaults) else $error("bad default address"); // R05

   property p_relocate_low;
      s_cfg_data_wr ##0 (index_q == CPD_IDX_BASE_LO)
         |=> base_lo_q == $past(io_wdata_in) && base_hi_q == $past(base_hi_q);
   endproperty
   a_relocate_low: assert property (p_relocate_low) else $error("relocation missed"); // R06

   property p_relocate_high;
      s_cfg_data_wr ##0 (index_q == CPD_IDX_BASE_HI)
         |=> base_hi_q == $past(io_wdata_in) && base_lo_q == $past(base_lo_q);
   endproperty
   a_relocate_high: assert property (p_relocate_high) else $error("high relocation missed"); // R06

   // Decode judged against the published base output, not the internal hit terms
   property p_claim_at_base;
      state_q == CPD_ST_CFG && (io_wr_in || io_rd_in) && (io_addr_in == cfg_base_addr_out
         || io_addr_in == 16'(cfg_base_addr_out + CPD_DATA_OFFSET)) |=> io_claim_out;
   endproperty
   a_claim_at_base: assert property (p_claim_at_base) else $error("port not decoded"); // R06 R09

   property p_enter;
      s_enter_key |=> state_q == CPD_ST_CFG && io_claim_out;
   endproperty
   a_enter: assert property (p_enter) else $error("entry key not taken"); // R07 R11

   property p_exit;
      state_q == CPD_ST_CFG && io_wr_in && hit_cfg && io_wdata_in == CPD_KEY_EXIT
         |=> state_q == CPD_ST_RUN && $stable(index_q);
   endproperty
   a_exit: assert property (p_exit) else $error("exit key not taken"); // R08

   property p_index_at_base;
      state_q == CPD_ST_CFG && io_wr_in && hit_cfg && io_wdata_in != CPD_KEY_EXIT
         |=> index_q == $past(io_wdata_in) && cfg_index_out == index_q;
   endproperty
   a_index_at_base: assert property (p_index_at_base) else $error("index write lost"); // R09

   property p_ignore_run;
      strap_done_q && state_q == CPD_ST_RUN && io_wr_in && hit_cfg
         && io_wdata_in != CPD_KEY_ENTER |=> state_q == CPD_ST_RUN && !io_claim_out;
   endproperty
   a_ignore_run: assert property (p_ignore_run) else $error("stray run write acted"); // R12
endmodule : cpd_config_port_decoder
`default_nettype wire

// *** test/cpd_host_model.sv ***
// Host bridge model: one-cycle configuration I/O strobes toward the decoder
`timescale 1ns/10ps
`default_nettype none
module cpd_host_model (
   input  wire logic        clk_in,
   input  wire logic        claim_in,
   input  wire logic [7:0]  rdata_in,
   output logic             wr_out,
   output logic             rd_out,
   output logic      [15:0] addr_out,
   output logic      [7:0]  wdata_out
);
   // Bus idle at time zero
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 16'hFFFF;
      wdata_out = 8'hFF;
   end

   // One access: strobe for one cycle, answer taken at the following edge
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic c, output logic [7:0] q);
      @(posedge clk_in);
      #1;
      wr_out = w;
      rd_out = ~w;
      addr_out = a;
      wdata_out = d;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      rd_out = 1'b0;
      // Released bus shows the inverse so stale values never look valid
      addr_out = ~a;
      wdata_out = ~d;
      c = claim_in;
      q = rdata_in;
   endtask : acc
endmodule : cpd_host_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the configuration port access decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
   import cpd_pkg::*;
   localparam logic [15:0] B = 16'h004E;
   logic        sys_clk_in, rst_in, lo_s, hi_s, io_wr, io_rd, claim, cfg_wr;
   logic [15:0] io_addr, base;
   logic [7:0]  io_wdata, cfg_rdata, rdata, idx, wdata, ldn;
   logic [1:0]  strap;
   cpd_state_t  st;
   int          n_errors, samples_checked, n_cfg_wr;

   cpd_config_port_decoder cpd_config_port_decoder_i (.sys_clk_in(sys_clk_in),
      .rst_in(rst_in), .cfg_addr_low_strap_in(lo_s), .cfg_addr_high_strap_in(hi_s),
      .io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr), .io_wdata_in(io_wdata),
      .cfg_rdata_in(cfg_rdata), .io_rdata_out(rdata), .io_claim_out(claim),
      .cfg_state_out(st), .cfg_wr_out(cfg_wr), .cfg_index_out(idx),
      .cfg_wdata_out(wdata), .ldn_out(ldn), .cfg_base_addr_out(base),
      .base_addr_strap_value_out(strap));
   cpd_host_model cpd_host_model_i (.clk_in(sys_clk_in), .claim_in(claim),
      .rdata_in(rdata), .wr_out(io_wr), .rd_out(io_rd), .addr_out(io_addr),
      .wdata_out(io_wdata));

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // Counts forwarded register writes; only one is expected in the whole run
   always @(posedge sys_clk_in) begin
      if (cfg_wr === 1'b1) n_cfg_wr++;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic c);
      logic       g;
      logic [7:0] q;
      cpd_host_model_i.acc(1'b1, a, d, g, q);
      chk("claim", {15'h0000, c}, {15'h0000, g});
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic c, input logic [7:0] e);
      logic       g;
      logic [7:0] q;
      cpd_host_model_i.acc(1'b0, a, 8'h00, g, q);
      chk("claim", {15'h0000, c}, {15'h0000, g});
      if (c) chk("rdata", {8'h00, e}, {8'h00, q});
   endtask : rd

   // Straps must be steady at the first edge after release
   task automatic do_reset(input logic h, input logic l);
      rst_in = 1'b1;
      hi_s = h;
      lo_s = l;
      repeat (16) @(posedge sys_clk_in);
      #1;
      rst_in = 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
   endtask : do_reset

   task automatic t_straps;
      logic [15:0] e [4] = '{16'h162E, 16'h164E, 16'h002E, 16'h004E};
      for (int i = 0; i < 4; i++) begin
         do_reset(i[1], i[0]);
         chk("base", e[i], base);
         chk("strap", 16'(i), {14'h0000, strap});
         chk("state", 16'h0000, {15'h0000, st});
         chk("ldn", 16'h0000, {8'h00, ldn});
      end
   endtask : t_straps

   task automatic t_run;
      wr(B, CPD_IDX_LDN, 1'b0);
      wr(B, CPD_KEY_EXIT, 1'b0);
      wr(B + 16'h0001, CPD_KEY_ENTER, 1'b0);
      rd(B + 16'h0001, 1'b0, 8'h00);
      chk("state", 16'h0000, {15'h0000, st});
   endtask : t_run

   task automatic t_cfg;
      wr(B, CPD_KEY_ENTER, 1'b1);
      chk("state", 16'h0001, {15'h0000, st});
      wr(B, CPD_IDX_LDN, 1'b1);
      wr(B + 16'h0001, 8'h08, 1'b1);
      chk("ldn", 16'h0008, {8'h00, ldn});
      wr(B, 8'hE0, 1'b1);
      wr(B + 16'h0001, 8'h02, 1'b1);
      chk("index", 16'h00E0, {8'h00, idx});
      chk("wdata", 16'h0002, {8'h00, wdata});
      chk("cfg_wr", 16'h0001, {15'h0000, cfg_wr});
      cfg_rdata = 8'h5A;
      rd(B + 16'h0001, 1'b1, 8'h5A);
      rd(B, 1'b1, 8'hE0);
      wr(B + 16'h0002, 8'h01, 1'b0);
   endtask : t_cfg

   task automatic t_move;
      wr(B, CPD_IDX_BASE_LO, 1'b1);
      wr(B + 16'h0001, 8'h60, 1'b1);
      chk("base", 16'h0060, base);
      wr(16'h0060, CPD_IDX_BASE_HI, 1'b1);
      wr(16'h0061, 8'h12, 1'b1);
      chk("base", 16'h1260, base);
      wr(B, CPD_KEY_EXIT, 1'b0);
      wr(16'h1260, CPD_KEY_EXIT, 1'b1);
      chk("state", 16'h0000, {15'h0000, st});
      wr(B, CPD_KEY_ENTER, 1'b0);
      wr(16'h1260, CPD_KEY_ENTER, 1'b1);
      rd(16'h1260, 1'b1, CPD_IDX_BASE_HI);
      rd(16'h1261, 1'b1, 8'h12);
      wr(16'h1260, CPD_IDX_LDN, 1'b1);
      rd(16'h1261, 1'b1, 8'h08);
      wr(16'h1260, CPD_IDX_BASE_LO, 1'b1);
      rd(16'h1261, 1'b1, 8'h60);
      wr(16'h1260, CPD_KEY_ENTER, 1'b1);
      rd(16'h1260, 1'b1, CPD_KEY_ENTER);
      // The counter lags a pulse by one edge, so it is read only here
      chk("cfg_wr_count", 16'h0001, 16'(n_cfg_wr));
      // Reset from configuration state must undo relocation and device choice
      do_reset(1'b1, 1'b1);
      chk("state", 16'h0000, {15'h0000, st});
      chk("ldn", 16'h0000, {8'h00, ldn});
      chk("base", B, base);
   endtask : t_move

   task automatic give_verdict;
      $display("Errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // Guard against a hang: the whole run needs about 150 cycles
   initial begin
      repeat (3000) @(posedge sys_clk_in);
      n_errors++;
      give_verdict();
   end

   initial begin
      rst_in = 1'b1;
      lo_s = 1'b0;
      hi_s = 1'b0;
      cfg_rdata = 8'h00;
      t_straps();
      t_run();
      t_cfg();
      t_move();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
